// File: src/io_line_pkg.sv
// Package for the output line and trigger block.
// Assumes a 10 MHz pclk and an APB slave with 32-bit data.
package io_line_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned US_PER_S = 1_000_000;
    localparam int unsigned TICK_US = 1;
    localparam logic [3:0] CYC_PER_US = 4'((CLK_HZ / US_PER_S) * TICK_US);
    // ------------------------------------------------------------
    // Lines: inputs 1..2, outputs 3..4
    // ------------------------------------------------------------
    localparam int unsigned N_IN = 2;
    localparam int unsigned N_OUT = 2;
    localparam int unsigned N_LINES = N_IN + N_OUT;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_OUT_CTRL = 8'h00;
    localparam logic [7:0] OFS_OUT_LEVEL = 8'h04;
    localparam logic [7:0] OFS_STROBE = 8'h08;
    localparam logic [7:0] OFS_SNAPSHOT = 8'h0C;
    localparam logic [7:0] OFS_PULSE_W = 8'h10;
    localparam logic [7:0] OFS_PULSE_LAG = 8'h14;
    localparam logic [7:0] OFS_FILTER = 8'h18;
    localparam logic [7:0] OFS_TRIG = 8'h1C;
    localparam logic [7:0] OFS_FRAME_PER = 8'h20;
    localparam logic [7:0] OFS_EXPO_PER = 8'h24;
    localparam logic [7:0] OFS_PIN_BIND = 8'h28;
    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int unsigned SRC_W = 2;
    localparam int unsigned HOLD_POS = 4;
    localparam logic [1:0] RST_SRC = 2'h0;
    localparam logic [15:0] RST_PULSE_W = 16'h000A;
    localparam logic [15:0] RST_PULSE_LAG = 16'h0000;
    localparam logic [7:0] RST_FILTER = 8'h00;
    localparam logic [23:0] RST_FRAME_PER = 24'h0186A0;
    localparam logic [23:0] RST_EXPO_PER = 24'h002710;
    localparam logic [23:0] MIN_GAP_US = 24'h000001;
    // Connector binding codes per line: pin5/gnd3, pin7/gnd3, pin6/pwr4, pin8/pwr4
    localparam logic [31:0] PIN_BIND_CODES = 32'h84_64_73_53;
    // ------------------------------------------------------------
    // Output source select
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_OFF = 2'b00,
        SRC_HOST_DRIVEN = 2'b01,
        SRC_PULSE_ON_HOST_WRITE = 2'b10,
        SRC_EXPOSURE_ACTIVE = 2'b11
    } driver_select_t;
endpackage

// File: src/line_pulse.sv
// One delayed pulse generator for a single output line.
// Assumes a one-cycle microsecond tick from the caller's divider.
`timescale 1ns/10ps
`default_nettype none
module line_pulse (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic us_tick,
    input wire logic fire,
    input wire logic [15:0] lag_us,
    input wire logic [15:0] width_us,
    // Result
    output logic pulse
);
    typedef enum logic [1:0] {
        P_IDLE = 2'b00,
        P_LAG = 2'b01,
        P_HIGH = 2'b10
    } pulse_state_t;

    pulse_state_t state;
    logic [15:0] count;

    // A new fire while busy is ignored; the running pulse completes intact
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= P_IDLE;
            count <= 16'h0000;
            pulse <= 1'b0;
        end else begin
            unique case (state)
                P_IDLE: begin
                    if (fire && lag_us != 16'h0000) begin
                        state <= P_LAG;
                        count <= lag_us;
                    end else if (fire && width_us != 16'h0000) begin
                        state <= P_HIGH;
                        count <= width_us;
                        pulse <= 1'b1;
                    end
                end
                P_LAG: begin
                    if (us_tick) begin
                        if (count == 16'h0001) begin
                            state <= (width_us != 16'h0000) ? P_HIGH : P_IDLE;
                            count <= width_us;
                            pulse <= (width_us != 16'h0000);
                        end else begin
                            count <= count - 16'h0001;
                        end
                    end
                end
                P_HIGH: begin
                    if (us_tick) begin
                        if (count == 16'h0001) begin
                            state <= P_IDLE;
                            pulse <= 1'b0;
                        end else begin
                            count <= count - 16'h0001;
                        end
                    end
                end
                default: begin
                    state <= P_IDLE;
                    pulse <= 1'b0;
                end
            endcase
        end
    end
endmodule // line_pulse
`default_nettype wire

// File: src/output_line_sw_control.sv
// Output line control, line snapshot and exposure trigger selection.
// Assumes an APB master on pclk; line inputs arrive from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module output_line_sw_control (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Lines
    input wire logic [io_line_pkg::N_IN-1:0] line_in,
    output logic [io_line_pkg::N_OUT-1:0] out_switch_closed,
    // Exposure
    output logic exposure_start,
    output logic exposure_active
);
    import io_line_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    driver_select_t src [N_OUT];
    logic [N_OUT-1:0] hold_latch;
    logic [N_OUT-1:0] sw_output_level;
    logic [15:0] pulse_width_us;
    logic [15:0] pulse_lag_us;
    logic [7:0] glitch_filter_time [N_IN];
    logic trig_gate;
    logic trig_origin;
    logic host_trig;
    logic [23:0] frame_per_us;
    logic [23:0] expo_per_us;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire hit_ctrl = paddr == OFS_OUT_CTRL;
    wire hit_level = paddr == OFS_OUT_LEVEL;
    wire hit_strobe = paddr == OFS_STROBE;
    wire hit_snap = paddr == OFS_SNAPSHOT;
    wire hit_pw = paddr == OFS_PULSE_W;
    wire hit_lag = paddr == OFS_PULSE_LAG;
    wire hit_filt = paddr == OFS_FILTER;
    wire hit_trig = paddr == OFS_TRIG;
    wire hit_fper = paddr == OFS_FRAME_PER;
    wire hit_eper = paddr == OFS_EXPO_PER;
    wire hit_bind = paddr == OFS_PIN_BIND;
    wire mapped = hit_ctrl | hit_level | hit_strobe | hit_snap | hit_pw | hit_lag
                | hit_filt | hit_trig | hit_fper | hit_eper | hit_bind;
    wire strobe_wr = wr && hit_strobe;

    // ------------------------------------------------------------
    // Microsecond tick
    // ------------------------------------------------------------
    logic [3:0] div;
    wire us_tick = div == CYC_PER_US - 4'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 4'h0;
        end else begin
            div <= us_tick ? 4'h0 : div + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_latch <= '0;
            sw_output_level <= '0;
            pulse_width_us <= RST_PULSE_W;
            pulse_lag_us <= RST_PULSE_LAG;
            trig_gate <= 1'b0;
            trig_origin <= 1'b0;
            frame_per_us <= RST_FRAME_PER;
            expo_per_us <= RST_EXPO_PER;
        end else begin
            if (wr && hit_ctrl) begin
                hold_latch <= {pwdata[8+HOLD_POS+1], pwdata[HOLD_POS]};
            end
            if (wr && hit_level) begin
                sw_output_level <= pwdata[N_OUT-1:0];
            end
            if (wr && hit_pw) begin
                pulse_width_us <= pwdata[15:0];
            end
            if (wr && hit_lag) begin
                pulse_lag_us <= pwdata[15:0];
            end
            if (wr && hit_trig) begin
                trig_gate <= pwdata[0];
                trig_origin <= pwdata[1];
            end
            if (wr && hit_fper) begin
                frame_per_us <= pwdata[23:0];
            end
            if (wr && hit_eper) begin
                expo_per_us <= pwdata[23:0];
            end
        end
    end

    // Host trigger command is self-clearing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_trig <= 1'b0;
        end else begin
            host_trig <= wr && hit_trig && pwdata[2];
        end
    end

    // ------------------------------------------------------------
    // Per-output logic
    // ------------------------------------------------------------
    logic [N_OUT-1:0] held_level;
    logic [N_OUT-1:0] pulse;
    logic [N_OUT-1:0] next_out;

    genvar g;
    generate
        for (g = 0; g < N_OUT; g++) begin : g_out
            wire host_src = src[g] == SRC_HOST_DRIVEN;
            wire pulse_src = src[g] == SRC_PULSE_ON_HOST_WRITE;
            // Bit g of the strobe word drives output g+1
            wire strobe_bit = strobe_wr && pwdata[g];
            wire latched = host_src && hold_latch[g];
            wire latch_hit = strobe_bit && latched;
            wire fire = strobe_bit && pulse_src;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    src[g] <= driver_select_t'(RST_SRC);
                    held_level[g] <= 1'b0;
                end else begin
                    if (wr && hit_ctrl) begin
                        src[g] <= driver_select_t'(pwdata[8*g +: SRC_W]);
                    end
                    // Tracks the level until latched, so entering latch mode keeps the pin
                    if (latch_hit || !latched) begin
                        held_level[g] <= sw_output_level[g];
                    end
                end
            end

            line_pulse u_pulse (
                .pclk(pclk),
                .presetn(presetn),
                .us_tick(us_tick),
                .fire(fire),
                .lag_us(pulse_lag_us),
                .width_us(pulse_width_us),
                .pulse(pulse[g])
            );

            // Level setting only matters for host driven outputs
            always_comb begin
                unique case (src[g])
                    SRC_OFF: next_out[g] = 1'b0;
                    SRC_HOST_DRIVEN: next_out[g] = hold_latch[g] ? held_level[g]
                                                                 : sw_output_level[g];
                    SRC_PULSE_ON_HOST_WRITE: next_out[g] = pulse[g];
                    SRC_EXPOSURE_ACTIVE: next_out[g] = exposure_active;
                endcase
            end
        end
    endgenerate

    // One means switch closed (active), zero means open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_switch_closed <= '0;
        end else begin
            out_switch_closed <= next_out;
        end
    end

    // ------------------------------------------------------------
    // Input synchronise and debounce
    // ------------------------------------------------------------
    logic [N_IN-1:0] in_meta;
    logic [N_IN-1:0] in_sync;
    logic [N_IN-1:0] in_clean;
    logic [7:0] filt_cnt [N_IN];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_meta <= '0;
            in_sync <= '0;
        end else begin
            in_meta <= line_in;
            in_sync <= in_meta;
        end
    end

    generate
        for (g = 0; g < N_IN; g++) begin : g_in
            // New level must hold for the whole filter time before it is taken
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    glitch_filter_time[g] <= RST_FILTER;
                    filt_cnt[g] <= 8'h00;
                    in_clean[g] <= 1'b0;
                end else begin
                    if (wr && hit_filt) begin
                        glitch_filter_time[g] <= pwdata[8*g +: 8];
                    end
                    if (in_sync[g] == in_clean[g]) begin
                        filt_cnt[g] <= 8'h00;
                    end else if (filt_cnt[g] >= glitch_filter_time[g]) begin
                        in_clean[g] <= in_sync[g];
                        filt_cnt[g] <= 8'h00;
                    end else if (us_tick) begin
                        filt_cnt[g] <= filt_cnt[g] + 8'h01;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Exposure triggering
    // ------------------------------------------------------------
    logic trig_prev;
    logic [23:0] frame_cnt;
    logic [23:0] expo_cnt;
    wire ext_level = in_clean[trig_origin];
    wire ext_rise = ext_level && !trig_prev;
    wire run_free = !trig_gate && frame_cnt == 24'h000000;
    // Frame period never shorter than the exposure plus a gap
    wire [23:0] eff_frame = (frame_per_us > expo_per_us) ? frame_per_us
                                                         : expo_per_us + MIN_GAP_US;
    wire start = !exposure_active && (run_free || (trig_gate && (ext_rise || host_trig)));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev <= 1'b0;
            frame_cnt <= 24'h000000;
            expo_cnt <= 24'h000000;
            exposure_start <= 1'b0;
            exposure_active <= 1'b0;
        end else begin
            trig_prev <= ext_level;
            exposure_start <= start;
            if (start) begin
                exposure_active <= 1'b1;
                expo_cnt <= expo_per_us;
                frame_cnt <= eff_frame;
            end else begin
                if (us_tick && frame_cnt != 24'h000000) begin
                    frame_cnt <= frame_cnt - 24'h000001;
                end
                if (us_tick && exposure_active) begin
                    expo_cnt <= expo_cnt - 24'h000001;
                    if (expo_cnt <= 24'h000001) begin
                        exposure_active <= 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [31:0] ctrl_word = {18'h00000, hold_latch[1], 3'h0, 2'(src[1]),
                             3'h0, hold_latch[0], 2'h0, 2'(src[0])};
    // Line one in bit zero, sampled at the read
    wire [31:0] snap_word = {28'h0000000, out_switch_closed, in_clean};
    wire [31:0] rd_mux =
        hit_ctrl ? ctrl_word :
        hit_level ? {30'h00000000, sw_output_level} :
        hit_snap ? snap_word :
        hit_pw ? {16'h0000, pulse_width_us} :
        hit_lag ? {16'h0000, pulse_lag_us} :
        hit_filt ? {16'h0000, glitch_filter_time[1], glitch_filter_time[0]} :
        hit_trig ? {30'h00000000, trig_origin, trig_gate} :
        hit_fper ? {8'h00, frame_per_us} :
        hit_eper ? {8'h00, expo_per_us} :
        hit_bind ? PIN_BIND_CODES :
        32'h00000000;

    // Zero-wait slave: answers in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
        end
    end
endmodule // output_line_sw_control
`default_nettype wire

// File: testbench/output_line_sw_control_properties.sv
// Checker for the APB, line and exposure ports of the output line block.
// Bound to every output_line_sw_control instance; one clock domain only.
`timescale 1ns/10ps
`default_nettype none
module output_line_sw_control_checker (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Lines and exposure
    input wire logic [io_line_pkg::N_IN-1:0] line_in,
    input wire logic [io_line_pkg::N_OUT-1:0] out_switch_closed,
    input wire logic exposure_start,
    input wire logic exposure_active
);
    import io_line_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_done = pready && psel && penable && !pwrite;
    property p_zero_wait; psel && !penable |=> pready; endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("no answer after setup");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready held");
    property p_bind; rd_done && paddr == OFS_PIN_BIND |-> prdata == PIN_BIND_CODES; endproperty
    a_bind: assert property (p_bind) else $error("pin binding wrong");
    property p_snap;
        rd_done && paddr == OFS_SNAPSHOT |-> prdata[31:4] == 28'h0
            && (prdata[3:2] == out_switch_closed || prdata[3:2] == $past(out_switch_closed));
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot differs from pins");
    property p_strobe_wo; rd_done && paddr == OFS_STROBE |-> prdata == 32'h0; endproperty
    a_strobe_wo: assert property (p_strobe_wo) else $error("strobe reads back");
    property p_unmapped; pready && paddr > OFS_PIN_BIND |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_start_once; exposure_start |=> !exposure_start; endproperty
    a_start_once: assert property (p_start_once) else $error("start too long");
    property p_start_exposes; exposure_start |-> ##[0:2] exposure_active; endproperty
    a_start_exposes: assert property (p_start_exposes) else $error("no exposure");
    property p_busy;
        exposure_active && $past(exposure_active) && $past(exposure_active, 2) |-> !exposure_start;
    endproperty
    a_busy: assert property (p_busy) else $error("start inside exposure");
endmodule // output_line_sw_control_checker
bind output_line_sw_control output_line_sw_control_checker i_output_line_sw_control_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .out_switch_closed(out_switch_closed),
    .exposure_start(exposure_start), .exposure_active(exposure_active));
`default_nettype wire

// File: testbench/line_gear.sv
// External trigger source and lighting load on the far side of the lines.
// Assumes the bench sets the wanted input levels; wire changes off pclk's edge.
`timescale 1ns/10ps
`default_nettype none
module line_gear (
    // Clock
    input wire logic pclk,
    // Input lines
    input wire logic [io_line_pkg::N_IN-1:0] level,
    output logic [io_line_pkg::N_IN-1:0] line_in,
    // Lighting load
    input wire logic [io_line_pkg::N_OUT-1:0] switch_closed,
    output logic [io_line_pkg::N_OUT-1:0] lamp_on
);
    import io_line_pkg::*;
    // Unrelated source: moves on the falling edge, so sync flops see it late
    always @(negedge pclk) begin
        line_in <= level;
    end
    assign lamp_on = switch_closed;
endmodule // line_gear
`default_nettype wire

// File: testbench/output_line_sw_control_tb_top.sv
// Self-checking bench for the output line block, APB master and line gear.
// Assumes a zero wait APB slave; frame and exposure shortened at start.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module output_line_sw_control_tb_top;
    import io_line_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [1:0] level = 2'b00, line_in, outs, lamps;
    logic e_start, e_act;
    int error_cnt = 0, n_tests = 0, cyc = 0, c, n, w;
    output_line_sw_control i_output_line_sw_control (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
        .out_switch_closed(outs), .exposure_start(e_start), .exposure_active(e_act));
    line_gear i_line_gear (.pclk(pclk), .level(level), .line_in(line_in),
        .switch_closed(outs), .lamp_on(lamps));
    always #50 pclk = ~pclk;
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                       output logic err);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) error_cnt++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic err;
        apb(1'b1, a, d, err);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic err;
        apb(1'b0, a, 32'h0, err);
        `CHK(r, x)
        `CHK(err, xe)
    endtask
    task automatic pins(input logic [1:0] x);
        repeat (3) @(posedge pclk);
        `CHK(outs, x)
        `CHK(lamps, x)
    endtask
    task automatic count(input int k);
        c = 0;
        repeat (k) begin
            @(posedge pclk);
            if (e_start === 1'b1) c++;
        end
    endtask
    // Output 2 hold flag sits at bit 13, its source at bits 9:8
    function automatic logic [31:0] ctrl(logic [1:0] s1, logic h1, logic [1:0] s2, logic h2);
        ctrl = 32'(s1) | (32'(h1) << HOLD_POS) | (32'(s2) << 8) | (32'(h2) << 13);
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rdchk(OFS_PIN_BIND, PIN_BIND_CODES, 1'b0);
        wr(OFS_PIN_BIND, 32'h0);
        rdchk(OFS_PIN_BIND, PIN_BIND_CODES, 1'b0);
        rdchk(OFS_PULSE_W, 32'(RST_PULSE_W), 1'b0);
        rdchk(OFS_FRAME_PER, 32'(RST_FRAME_PER), 1'b0);
        rdchk(OFS_STROBE, 32'h0, 1'b0);
        wr(8'h2C, 32'hFFFFFFFF);
        rdchk(8'h2C, 32'h0, 1'b1);
        wr(OFS_EXPO_PER, 32'h5);
        wr(OFS_FRAME_PER, 32'h28);
        $display("test regs done");
    endtask
    task automatic t_levels();
        wr(OFS_OUT_CTRL, ctrl(SRC_HOST_DRIVEN, 0, SRC_HOST_DRIVEN, 0));
        for (int v = 0; v < 4; v++) begin
            wr(OFS_OUT_LEVEL, 32'(v));
            pins(2'(v));
        end
        wr(OFS_OUT_CTRL, ctrl(SRC_HOST_DRIVEN, 0, SRC_OFF, 0));
        pins(2'b01);
        wr(OFS_OUT_CTRL, ctrl(SRC_HOST_DRIVEN, 0, SRC_PULSE_ON_HOST_WRITE, 0));
        pins(2'b01);
        wr(OFS_OUT_CTRL, ctrl(SRC_HOST_DRIVEN, 1, SRC_HOST_DRIVEN, 1));
        wr(OFS_OUT_LEVEL, 32'h0);
        pins(2'b11);
        wr(OFS_STROBE, 32'h1);
        pins(2'b10);
        wr(OFS_STROBE, 32'h2);
        pins(2'b00);
        wr(OFS_OUT_LEVEL, 32'h3);
        wr(OFS_STROBE, 32'h3);
        pins(2'b11);
        wr(OFS_OUT_CTRL, ctrl(SRC_HOST_DRIVEN, 1, SRC_OFF, 0));
        wr(OFS_OUT_LEVEL, 32'h0);
        wr(OFS_STROBE, 32'h3);
        pins(2'b00);
        $display("test levels done");
    endtask
    task automatic t_pulse();
        wr(OFS_PULSE_W, 32'h3);
        wr(OFS_PULSE_LAG, 32'h2);
        wr(OFS_OUT_CTRL, ctrl(SRC_PULSE_ON_HOST_WRITE, 0, SRC_EXPOSURE_ACTIVE, 1));
        wr(OFS_STROBE, 32'h1);
        for (n = 0; outs[0] !== 1'b1 && n < 100; n++) @(posedge pclk);
        for (w = 0; outs[0] === 1'b1 && w < 100; w++) @(posedge pclk);
        `CHK(n >= 11 && n <= 23, 1'b1)
        `CHK(w >= 21 && w <= 30, 1'b1)
        $display("test pulse done");
    endtask
    task automatic t_lines();
        wr(OFS_OUT_CTRL, ctrl(SRC_HOST_DRIVEN, 0, SRC_OFF, 0));
        wr(OFS_OUT_LEVEL, 32'h1);
        level <= 2'b10;
        repeat (10) @(posedge pclk);
        rdchk(OFS_SNAPSHOT, 32'h6, 1'b0);
        wr(OFS_FILTER, 32'hFF05);
        rdchk(OFS_FILTER, 32'hFF05, 1'b0);
        level <= 2'b01;
        repeat (20) @(posedge pclk);
        level <= 2'b00;
        // Line two stays high: its 255 us filter outlasts this whole test
        repeat (80) @(posedge pclk);
        rdchk(OFS_SNAPSHOT, 32'h6, 1'b0);
        level <= 2'b01;
        repeat (30) @(posedge pclk);
        rdchk(OFS_SNAPSHOT, 32'h6, 1'b0);
        repeat (50) @(posedge pclk);
        rdchk(OFS_SNAPSHOT, 32'h7, 1'b0);
        $display("test lines done");
    endtask
    task automatic t_trig();
        level <= 2'b00;
        wr(OFS_OUT_CTRL, ctrl(SRC_OFF, 0, SRC_EXPOSURE_ACTIVE, 0));
        wr(OFS_FILTER, 32'h0);
        wr(OFS_TRIG, 32'h1);
        for (n = 0; e_act !== 1'b0 && n < 101000; n++) @(posedge pclk);
        count(300);
        `CHK(c, 0)
        level <= 2'b01;
        count(100);
        `CHK(c, 1)
        wr(OFS_TRIG, 32'h3);
        level <= 2'b00;
        count(100);
        `CHK(c, 0)
        level <= 2'b10;
        count(100);
        `CHK(c, 1)
        wr(OFS_TRIG, 32'h7);
        count(3);
        `CHK(c, 1)
        `CHK(outs, 2'b10)
        count(97);
        `CHK(c, 0)
        wr(OFS_TRIG, 32'h0);
        count(2000);
        `CHK(c >= 4 && c <= 6, 1'b1)
        wr(OFS_EXPO_PER, 32'h1E);
        wr(OFS_FRAME_PER, 32'hA);
        repeat (400) @(posedge pclk);
        count(2000);
        `CHK(c >= 1 && c <= 7, 1'b1)
        $display("test trigger done");
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Ceiling covers one full default exposure plus all scenarios
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 140000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_levels();
        t_pulse();
        t_lines();
        t_trig();
        conclude();
    end
endmodule // output_line_sw_control_tb_top
`default_nettype wire
